/* hw/tmx_timer_x.sv */
// timer x with its mode register, count pin handling and real-time outputs
//
// Design decision made here: the plain strobed port.
module tmx_timer_x
  import tmx_pkg::*;
#(
  parameter int TICK_DIV = TMX_TICK_DIV
) (
  input wire logic clock, // 250 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire tmx_bus_req_t bus_req, // register bus request
  output logic [TMX_DATA_W-1:0] bus_rdata, // read data, cycle after the read strobe
  input wire logic count_input_pin_zero_in, // count pin level from outside
  output logic count_input_pin_zero_out, // pulse level driven on the count pin
  output logic count_input_pin_zero_oe, // count pin driven (pulse output mode)
  output logic realtime_out_zero, // real-time output 0 level
  output logic realtime_out_one, // real-time output 1 level
  output logic realtime_oe, // real-time outputs driven
  output logic underflow_pulse, // one cycle per counter underflow
  output logic pin_event_pulse // one cycle per active count pin edge
);
  tmx_state_t st_reg;
  tmx_state_t st_next;
  logic wr_mode;
  logic wr_data;
  logic tick;
  logic rise;
  logic fall;
  logic dec;

  assign wr_mode = bus_req.wr && (bus_req.addr == TMX_MODE_ADDR);
  assign wr_data = bus_req.wr && (bus_req.addr == TMX_DATA_ADDR);
  assign tick = (st_reg.presc == 8'(TICK_DIV - 1));
  assign rise = st_reg.filt && !st_reg.filt_d;
  assign fall = !st_reg.filt && st_reg.filt_d;

  always_comb begin
    st_next = st_reg;
    st_next.uflow = 1'b0;
    st_next.pin_evt = 1'b0;
    st_next.rdata = '0;
    // the divider free-runs so a stop does not skew the next period
    st_next.presc = tick ? 8'h00 : st_reg.presc + 8'h01;
    // pin synchroniser; a level is taken once stages two and three agree
    st_next.s1 = count_input_pin_zero_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.filt = st_reg.s3;
    end
    st_next.filt_d = st_reg.filt;
    st_next.pin_evt = st_reg.mode.edge_sel ? rise : fall;
    dec = 1'b0;
    case (st_reg.mode.opmode)
      TMX_OP_TIMER: dec = tick;
      TMX_OP_PULSE: dec = tick;
      TMX_OP_EVENT: dec = st_reg.mode.edge_sel ? fall : rise;
      TMX_OP_WIDTH: dec = tick && (st_reg.filt == !st_reg.mode.edge_sel);
      default: dec = 1'b0;
    endcase
    if (dec && !st_reg.mode.stop) begin
      if (st_reg.count == '0) begin
        st_next.count = st_reg.latch;
        st_next.uflow = 1'b1;
        if (st_reg.mode.opmode == TMX_OP_PULSE) begin
          st_next.pulse = !st_reg.pulse;
        end
      end else begin
        st_next.count = st_reg.count - 8'h01;
      end
    end
    if (wr_data) begin
      st_next.latch = bus_req.wdata;
      if (!st_reg.mode.latch_only) begin
        st_next.count = bus_req.wdata;
      end
    end
    if (wr_mode) begin
      st_next.mode = tmx_mode_t'(bus_req.wdata);
      st_next.pulse = !bus_req.wdata[6];
    end
    if (bus_req.rd) begin
      if (bus_req.addr == TMX_MODE_ADDR) begin
        st_next.rdata = st_reg.mode;
      end else if (bus_req.addr == TMX_DATA_ADDR) begin
        st_next.rdata = st_reg.count;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= TMX_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign count_input_pin_zero_out = st_reg.pulse;
  assign count_input_pin_zero_oe = (st_reg.mode.opmode == TMX_OP_PULSE);
  assign realtime_oe = st_reg.mode.rt_en;
  assign realtime_out_zero = st_reg.mode.rt_en && st_reg.mode.rt_lvl_zero;
  assign realtime_out_one = st_reg.mode.rt_en && st_reg.mode.rt_lvl_one;
  assign underflow_pulse = st_reg.uflow;
  assign pin_event_pulse = st_reg.pin_evt;

  property p_wr_both;
    @(posedge clock) disable iff (rst)
    (wr_data && !st_reg.mode.latch_only) |=> (st_reg.count == $past(bus_req.wdata))
      && (st_reg.latch == $past(bus_req.wdata));
  endproperty
  a_wr_both: assert property (p_wr_both) else $error("counter not loaded by write");

  property p_wr_latch;
    @(posedge clock) disable iff (rst)
    (wr_data && st_reg.mode.latch_only && st_reg.mode.stop) |=>
      $stable(st_reg.count) && (st_reg.latch == $past(bus_req.wdata));
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("latch-only write hit counter");

  property p_rt_en;
    @(posedge clock) disable iff (rst)
    wr_mode |=> (realtime_oe == $past(bus_req.wdata[1]));
  endproperty
  a_rt_en: assert property (p_rt_en) else $error("real-time enable wrong");

  property p_rt_lvl;
    @(posedge clock) disable iff (rst)
    (wr_mode && bus_req.wdata[1]) |=> (realtime_out_zero == $past(bus_req.wdata[2]))
      && (realtime_out_one == $past(bus_req.wdata[3]));
  endproperty
  a_rt_lvl: assert property (p_rt_lvl) else $error("real-time level wrong");

  property p_pin_evt;
    @(posedge clock) disable iff (rst)
    pin_event_pulse |-> $past(st_reg.filt) == $past(st_reg.mode.edge_sel)
      && $past(st_reg.filt != st_reg.filt_d);
  endproperty
  a_pin_evt: assert property (p_pin_evt) else $error("pin event on wrong edge");

  property p_pulse_init;
    @(posedge clock) disable iff (rst)
    (wr_mode && bus_req.wdata[5:4] == TMX_OP_PULSE) |=>
      count_input_pin_zero_oe && (count_input_pin_zero_out == !$past(bus_req.wdata[6]));
  endproperty
  a_pulse_init: assert property (p_pulse_init) else $error("pulse start level wrong");

  property p_event_cnt;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.opmode == TMX_OP_EVENT && !st_reg.mode.stop && !wr_data
      && (st_reg.mode.edge_sel ? fall : rise) && st_reg.count != '0)
      |=> st_reg.count == $past(st_reg.count) - 8'h01;
  endproperty
  a_event_cnt: assert property (p_event_cnt) else $error("event edge not counted");

  property p_width_hold;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.opmode == TMX_OP_WIDTH && !wr_data
      && st_reg.filt == st_reg.mode.edge_sel) |=> $stable(st_reg.count);
  endproperty
  a_width_hold: assert property (p_width_hold) else $error("counted wrong level");

  property p_stop;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.stop && !wr_data) |=> $stable(st_reg.count) && !underflow_pulse;
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_reset;
    @(posedge clock) disable iff (rst)
    $fell(rst) |-> (st_reg.mode == TMX_MODE_RST) && !realtime_oe && bus_rdata == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("mode not cleared by reset");

  property p_rdata_mode;
    @(posedge clock) disable iff (rst)
    (bus_req.rd && bus_req.addr == TMX_MODE_ADDR) |=> bus_rdata == $past(st_reg.mode);
  endproperty
  a_rdata_mode: assert property (p_rdata_mode) else $error("mode readback wrong");

  // read data stand one cycle only, so a stale word never looks like a fresh answer
  property p_rdata_idle;
    @(posedge clock) disable iff (rst)
    !bus_req.rd |=> bus_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

  property p_timer_hold;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.opmode == TMX_OP_TIMER && !tick && !wr_data) |=> $stable(st_reg.count);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved off tick");

  property p_uflow_reload;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.opmode == TMX_OP_TIMER && !st_reg.mode.stop && tick && !wr_data
      && st_reg.count == '0) |=> st_reg.count == $past(st_reg.latch) && underflow_pulse;
  endproperty
  a_uflow_reload: assert property (p_uflow_reload) else $error("no reload at underflow");

  property p_pulse_tgl;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.opmode == TMX_OP_PULSE && !st_reg.mode.stop && tick && !wr_mode
      && st_reg.count == '0) |=> count_input_pin_zero_out != $past(count_input_pin_zero_out);
  endproperty
  a_pulse_tgl: assert property (p_pulse_tgl) else $error("pulse pin did not flip");

  property p_width_cnt;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.opmode == TMX_OP_WIDTH && !st_reg.mode.stop && tick && !wr_data
      && st_reg.filt != st_reg.mode.edge_sel && st_reg.count != '0)
      |=> st_reg.count == $past(st_reg.count) - 8'h01;
  endproperty
  a_width_cnt: assert property (p_width_cnt) else $error("measured level not counted");

  property p_evt_edge;
    @(posedge clock) disable iff (rst)
    (st_reg.mode.edge_sel ? rise : fall) |=> pin_event_pulse;
  endproperty
  a_evt_edge: assert property (p_evt_edge) else $error("active pin edge missed");

  c_uflow: cover property (@(posedge clock) disable iff (rst) underflow_pulse);
  c_pin_evt: cover property (@(posedge clock) disable iff (rst) pin_event_pulse);
  c_pulse_tgl: cover property (@(posedge clock) disable iff (rst)
    count_input_pin_zero_oe && $changed(count_input_pin_zero_out) && !$past(wr_mode));
  c_event_cnt: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode.opmode == TMX_OP_EVENT && dec);
  c_width_cnt: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode.opmode == TMX_OP_WIDTH && dec);
endmodule // tmx_timer_x

/* hw/tmx_pkg.sv */
// constants, register layout and carrier types for the timer x mode control block
//
// Contract
// - write control 0 loads latch and counter; 1 loads the latch only
// - real-time port control 1 enables the real-time outputs; 0 disables them
// - bits 2 and 3 hold the levels driven on the two real-time outputs
// - bits 5:4 pick timer, pulse output, event counter or pulse width mode
// - edge select 0 makes the count pin event falling-edge, 1 rising-edge
// - in pulse output mode edge select 0 starts output high, 1 starts low
// - event counter counts rising pin edges when edge select is 0, falling when 1
// - pulse width mode counts during high level when edge select 0, low when 1
// - stop bit 0 lets the timer count, 1 halts it
package tmx_pkg;
  localparam int TMX_DATA_W = 8;
  localparam int TMX_ADDR_W = 8;
  localparam int TMX_TICK_DIV = 16;

  // register offsets; the bus is byte wide, so each offset is its own address
  localparam logic [7:0] TMX_MODE_IDX = 8'h27;
  localparam logic [7:0] TMX_DATA_IDX = 8'h2c;
  localparam logic [7:0] TMX_MODE_ADDR = TMX_MODE_IDX;
  localparam logic [7:0] TMX_DATA_ADDR = TMX_DATA_IDX;

  localparam logic [1:0] TMX_OP_TIMER = 2'h0;
  localparam logic [1:0] TMX_OP_PULSE = 2'h1;
  localparam logic [1:0] TMX_OP_EVENT = 2'h2;
  localparam logic [1:0] TMX_OP_WIDTH = 2'h3;

  // bit 7 down to bit 0 of the mode register
  typedef struct packed {
    logic stop;
    logic edge_sel;
    logic [1:0] opmode;
    logic rt_lvl_one;
    logic rt_lvl_zero;
    logic rt_en;
    logic latch_only;
  } tmx_mode_t;

  typedef struct packed {
    logic [TMX_ADDR_W-1:0] addr;
    logic [TMX_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tmx_bus_req_t;

  typedef struct packed {
    tmx_mode_t mode;
    logic [TMX_DATA_W-1:0] latch;
    logic [TMX_DATA_W-1:0] count;
    logic [7:0] presc;
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic filt_d;
    logic pulse;
    logic uflow;
    logic pin_evt;
    logic [TMX_DATA_W-1:0] rdata;
  } tmx_state_t;

  localparam tmx_mode_t TMX_MODE_RST = 8'h00;
  localparam tmx_state_t TMX_STATE_RST = '{mode: TMX_MODE_RST, pulse: 1'b1, default: '0};
endpackage

/* tb/tmx_pin_model.sv */
// external source on the count pin: makes a given number of level toggles
module tmx_pin_model (
  input wire logic clock, // system clock
  input wire logic go, // one-cycle start request
  input wire logic [3:0] n, // toggles to make, taken with go
  output logic pin // level driven on the count pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left = 4'h0;
  logic [2:0] hold = 3'h0;
  logic lvl = 1'b0;
  assign pin = lvl;
  // each level is held eight cycles, well above the synchroniser's minimum width
  always @(posedge clock) begin
    if (go) begin
      left <= n;
    end else if (left != 4'h0) begin
      hold <= hold + 3'h1;
      if (hold == 3'h7) begin
        lvl <= ~lvl;
        left <= left - 4'h1;
      end
    end
  end
endmodule // tmx_pin_model

/* tb/test_tmx_timer_x.sv */
// self-checking bench for the timer x mode control block
module test_tmx_timer_x
  import tmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  tmx_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata, d;
  logic pin_out, pin_oe, ext_pin, rt0, rt1, rt_oe, evt, uf;
  logic go = 1'b0;
  logic [3:0] n_tgl = 4'h0;
  int n_mismatch = 0, check_count = 0, cycles = 0, n_evt = 0, e0 = 0, n_uf = 0, u0 = 0;
  logic [7:0] mv [4] = '{8'hff, 8'h06, 8'h0c, 8'h0a};
  logic [2:0] rv [4] = '{3'b111, 3'b110, 3'b000, 3'b101};
  wire pin_lvl = pin_oe ? pin_out : ext_pin;
  always #2 clock = ~clock;
  tmx_timer_x #(.TICK_DIV(2)) uut (.clock(clock), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .count_input_pin_zero_in(pin_lvl),
    .count_input_pin_zero_out(pin_out), .count_input_pin_zero_oe(pin_oe),
    .realtime_out_zero(rt0), .realtime_out_one(rt1), .realtime_oe(rt_oe),
    .underflow_pulse(uf), .pin_event_pulse(evt));
  tmx_pin_model pm (.clock(clock), .go(go), .n(n_tgl), .pin(ext_pin));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (evt === 1'b1) n_evt <= n_evt + 1;
    if (uf === 1'b1) n_uf <= n_uf + 1;
    if (cycles == 6000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic tgl(input logic [3:0] n);
    @(posedge clock);
    go <= 1'b1;
    n_tgl <= n;
    @(posedge clock);
    go <= 1'b0;
    repeat (8 * n + 12) @(posedge clock);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(TMX_MODE_ADDR);
    chk(d, 8'h00);
    rd(8'h00);
    chk(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(TMX_MODE_ADDR, mv[i]);
      settle();
      chk({5'h00, rt_oe, rt0, rt1}, {5'h00, rv[i]});
      rd(TMX_MODE_ADDR);
      chk(d, mv[i]);
    end
    $display("test register and real-time outputs done");
    wr(TMX_MODE_ADDR, 8'h80);
    wr(TMX_DATA_ADDR, 8'h05);
    wr(TMX_MODE_ADDR, 8'h81);
    wr(TMX_DATA_ADDR, 8'h09);
    u0 = n_uf;
    repeat (20) @(posedge clock);
    rd(TMX_DATA_ADDR);
    chk(d, 8'h05);
    chk(8'(n_uf - u0), 8'h00);
    // a loaded counter must have left its load value a few ticks later
    wr(TMX_MODE_ADDR, 8'h00);
    wr(TMX_DATA_ADDR, 8'h40);
    repeat (8) @(posedge clock);
    rd(TMX_DATA_ADDR);
    chk({7'h00, d < 8'h40 && d > 8'h30}, 8'h01);
    wr(TMX_DATA_ADDR, 8'h02);
    u0 = n_uf;
    repeat (20) @(posedge clock);
    chk({7'h00, n_uf - u0 > 1}, 8'h01);
    $display("test write control and stop done");
    wr(TMX_MODE_ADDR, 8'h90);
    settle();
    chk({6'h00, pin_oe, pin_out}, 8'h03);
    // running from a load of two, the pin flips about three ticks in
    wr(TMX_DATA_ADDR, 8'h02);
    wr(TMX_MODE_ADDR, 8'h10);
    settle();
    chk({6'h00, pin_oe, pin_out}, 8'h03);
    repeat (3) settle();
    chk({6'h00, pin_oe, pin_out}, 8'h02);
    wr(TMX_MODE_ADDR, 8'hd0);
    settle();
    chk({6'h00, pin_oe, pin_out}, 8'h02);
    $display("test pulse output start level done");
    // three toggles give two edges of the counted kind and one of the other
    for (int j = 0; j < 2; j++) begin
      wr(TMX_MODE_ADDR, j ? 8'h60 : 8'h20);
      wr(TMX_DATA_ADDR, 8'h10);
      settle();
      e0 = n_evt;
      tgl(4'h3);
      rd(TMX_DATA_ADDR);
      chk(d, 8'h0e);
      chk(8'(n_evt - e0), 8'h01);
    end
    $display("test event counter done");
    wr(TMX_MODE_ADDR, 8'h30);
    wr(TMX_DATA_ADDR, 8'h40);
    repeat (20) @(posedge clock);
    rd(TMX_DATA_ADDR);
    chk(d, 8'h40);
    wr(TMX_MODE_ADDR, 8'h70);
    repeat (20) @(posedge clock);
    rd(TMX_DATA_ADDR);
    chk({7'h00, d < 8'h40}, 8'h01);
    $display("test pulse width done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(TMX_MODE_ADDR);
    chk(d, 8'h00);
    $display("test second reset done");
    complete_run();
  end
endmodule // test_tmx_timer_x
